// [rtl/lbt_local_bus_target.v]
// Local bus target: decode, claim, ready timing, byte steering, write queue
`timescale 1ns/10ps
`include "lbt_map.vh"

// Contract
// R1: Burst transfers continue without new address strobe
// R2: Decode address 25..2 with memory/IO line
// R3: Claim accepted cycle by driving claim low
// R4: Others stay off once claim goes low
// R5: Outside logic decodes upper address select
// R6: Data/control line ignored; no special cycles
// R7: Never claim I/O 0002h through 0005h
// R8: Latch address at end of T1
// R9: No restart support, no back-off input
// R10: Host reset aligns derived 1x bus clock
// R11: Narrow host: detect pipelined cycles itself
// R12: Wide old host: no pipelined cycles
// R13: Wide hosts: size line low when claimed
// R14: Board pulls ready up while idle
// R15: Ready low one clock, high, release
// R16: Memory read ready only with valid data
// R17: Memory writes finish fast while queue free
// R18: Register I/O ready after four CPU clocks
// R19: Palette I/O ready after four video clocks
// R20: Even bytes low lane, odd high lane
// R21: Ready for every decoded I/O address
// R22: Unused I/O reads zero, writes dropped
// R23: Queue memory writes until memory free
// R24: Unclaimed cycles: claim high, ready off
module lbt_local_bus_target (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [1:0]  host_mode,
  input  wire        ads_n,
  input  wire        blast_n,
  input  wire        mio,
  input  wire        wr,
  input  wire [3:0]  be_n,
  input  wire [25:2] addr,
  input  wire        upper_address_select_n,
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg         data_oe,
  output reg         ldev_n,
  output reg         lbs16_n,
  output reg         rdy_out,
  output reg         rdy_oe,
  input  wire        video_clock,
  output reg         reg_req,
  output reg         reg_we,
  output reg  [15:0] reg_addr,
  output reg  [1:0]  reg_be,
  output reg  [15:0] reg_wdata,
  output reg         reg_pal,
  input  wire [1:0]  reg_used,
  input  wire [15:0] reg_rdata,
  output wire        mem_wr_valid,
  output reg  [15:0] mem_wr_addr,
  output reg  [15:0] mem_wr_data,
  output reg  [1:0]  mem_wr_be,
  input  wire        mem_wr_ready,
  output reg         mem_rd_req,
  output reg  [15:0] mem_rd_addr,
  input  wire        mem_rd_valid,
  input  wire [15:0] mem_rd_data
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_DEC   = 3'h1;
  localparam ST_MEMWR = 3'h2;
  localparam ST_MEMRD = 3'h3;
  localparam ST_REGW  = 3'h4;
  localparam ST_RDY   = 3'h5;
  localparam ST_RDYHI = 3'h6;
  localparam SYNC_W   = 52;
  localparam [31:0] RDY_HI_W = `LBT_RDY_HIGH_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg  [SYNC_W-1:0] pin_s1_q;
  reg  [SYNC_W-1:0] pin_s2_q;
  reg               video_clock_s3_q;
  wire              ads_s;
  wire              blast_s;
  wire              mio_s;
  wire              wr_s;
  wire [3:0]        be_s;
  wire [25:2]       addr_s;
  wire              uas_s;
  wire [15:0]       din_s;
  wire              video_clock_s;
  wire [1:0]        mode_s;

  always @(posedge core_clk)
  begin
    pin_s1_q  <= {host_mode, video_clock, ads_n, blast_n, mio, wr, be_n,
                  upper_address_select_n, addr, data_in};
    pin_s2_q  <= pin_s1_q;
    video_clock_s3_q <= video_clock_s;
  end

  assign din_s   = pin_s2_q[15:0];
  assign addr_s  = pin_s2_q[39:16];
  assign uas_s   = pin_s2_q[40];
  assign be_s    = pin_s2_q[44:41];
  assign wr_s    = pin_s2_q[45];
  assign mio_s   = pin_s2_q[46];
  assign blast_s = pin_s2_q[47];
  assign ads_s   = ~pin_s2_q[48];
  assign video_clock_s  = pin_s2_q[49];
  assign mode_s  = pin_s2_q[51:50];

  ////////////////////////////////////////////////////////////////////////////
  // Host mode strap and derived bus clock

  reg  [1:0] mode_q;
  reg        phase_q;
  wire       dbl_rate;
  wire       bus_tick;
  wire       video_clock_rise;

  always @(posedge core_clk)
  begin
    // Strap caught while reset is held
    if (rst)
      mode_q <= mode_s;
    // Host reset fixes the phase of the halved clock
    phase_q <= rst ? 1'b0 : ~phase_q;  // R10
  end

  assign dbl_rate  = (mode_q != `LBT_HM_W32);
  assign bus_tick  = ~dbl_rate | phase_q;  // R10
  assign video_clock_rise = video_clock_s & ~video_clock_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle latch and decode

  reg  [2:0]  st_q;
  reg  [25:2] addr_q;
  reg  [3:0]  be_q;
  reg         mio_q;
  reg         wr_q;
  reg         uas_q;
  reg         half_q;
  reg         claim_q;
  reg  [2:0]  hi_cnt_q;
  wire [1:0]  lane_be_n;
  wire        mem_hit;
  wire        io_win;
  wire        io_spc;
  wire        io_hit;
  wire        pal_hit;
  wire        hit;
  wire        more_half;
  wire        pipe_ok;
  wire        take_ads;

  // Byte enables of the half now on the 16-bit path
  assign lane_be_n = half_q ? be_q[3:2] : be_q[1:0];

  // Status line for data/control is not decoded at all; R6
  assign mem_hit = mio_q & ~uas_q & (addr_q[25:17] == `LBT_MEM_BASE);  // R2
  assign io_win  = ~mio_q & (addr_q[25:16] == 10'h000)
                 & (addr_q[15:2] >= `LBT_IO_LO) & (addr_q[15:2] <= `LBT_IO_HI);  // R2
  assign io_spc  = (addr_q[15:2] >= `LBT_SPC_LO) & (addr_q[15:2] <= `LBT_SPC_HI);
  assign io_hit  = io_win & ~io_spc;  // R7
  assign pal_hit = io_hit & (((addr_q[15:2] == `LBT_PAL_W0) & half_q)
                 | ((addr_q[15:2] == `LBT_PAL_W1) & ~half_q));
  assign hit     = mem_hit | io_hit;

  assign more_half = ~half_q & (be_q[3:2] != 2'h3);
  // Only the narrow host may start a pipelined cycle during ready
  assign pipe_ok   = (mode_q == `LBT_HM_N16);  // R11 R12
  assign take_ads  = ads_s & bus_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Write queue toward display memory

  reg  [33:0]           wq_mem [0:`LBT_WQ_DEPTH-1];
  reg  [`LBT_WQ_AW:0]   wq_wp_q;
  reg  [`LBT_WQ_AW:0]   wq_rp_q;
  wire                  wq_full;
  wire                  wq_empty;
  wire                  wq_push;
  wire                  wq_pop;
  wire [33:0]           wq_head;

  assign wq_empty = (wq_wp_q == wq_rp_q);
  assign wq_full  = (wq_wp_q[`LBT_WQ_AW-1:0] == wq_rp_q[`LBT_WQ_AW-1:0])
                  & (wq_wp_q[`LBT_WQ_AW] != wq_rp_q[`LBT_WQ_AW]);
  assign wq_push  = (st_q == ST_MEMWR) & ~wq_full;  // R17
  assign wq_pop   = mem_wr_valid & mem_wr_ready;
  assign wq_head  = wq_mem[wq_rp_q[`LBT_WQ_AW-1:0]];
  assign mem_wr_valid = ~wq_empty;  // R23

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      wq_wp_q <= {(`LBT_WQ_AW+1){1'b0}};
      wq_rp_q <= {(`LBT_WQ_AW+1){1'b0}};
    end
    else
    begin
      if (wq_push)
      begin
        // Host is released once address and data sit here
        wq_mem[wq_wp_q[`LBT_WQ_AW-1:0]] <= {~lane_be_n, addr_q[16:2], half_q, din_s};  // R23
        wq_wp_q <= wq_wp_q + 1'b1;
      end
      if (wq_pop)
        wq_rp_q <= wq_rp_q + 1'b1;
    end
  end

  always @*
  begin
    mem_wr_be   = wq_head[33:32];
    mem_wr_addr = wq_head[31:16];
    mem_wr_data = wq_head[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready delay for register and palette accesses

  wire tmr_start;
  wire tmr_done;

  assign tmr_start = (st_q == ST_DEC) & io_hit & bus_tick;

  lbt_ready_timer u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (tmr_start),
    .load     (pal_hit ? `LBT_DAC_DELAY : `LBT_IO_DELAY),
    .tick     (reg_pal ? video_clock_rise : bus_tick),  // R18 R19
    .done     (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state machine
  // No back-off input exists, so a restarted cycle is never noticed; R9

  reg rd_pend_q;

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      st_q      <= ST_IDLE;
      addr_q    <= 24'h000000;
      be_q      <= 4'hF;
      mio_q     <= 1'b0;
      wr_q      <= 1'b0;
      uas_q     <= 1'b1;
      half_q    <= 1'b0;
      claim_q   <= 1'b0;
      hi_cnt_q  <= 3'h0;
      rd_pend_q <= 1'b0;
      reg_req   <= 1'b0;
      reg_we    <= 1'b0;
      reg_addr  <= 16'h0000;
      reg_be    <= 2'h0;
      reg_wdata <= 16'h0000;
      reg_pal   <= 1'b0;
      mem_rd_req  <= 1'b0;
      mem_rd_addr <= 16'h0000;
      data_out  <= 16'h0000;
    end
    else
    begin
      reg_req    <= 1'b0;
      mem_rd_req <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (take_ads)
          begin
            // Address held here, so a later address hold cannot disturb it
            addr_q <= addr_s;  // R8
            be_q   <= be_s;
            mio_q  <= mio_s;
            wr_q   <= wr_s;
            uas_q  <= (mode_q == `LBT_HM_N16) ? 1'b0 : uas_s;
            half_q <= (be_s[1:0] == 2'h3);
            st_q   <= ST_DEC;
          end
        end
        ST_DEC:
        begin
          if (bus_tick)
          begin
            if (!hit)
            begin
              claim_q <= 1'b0;  // R24
              st_q    <= ST_IDLE;
            end
            else
            begin
              claim_q <= 1'b1;  // R3
              if (mem_hit)
                st_q <= wr_q ? ST_MEMWR : ST_MEMRD;
              else
              begin
                // Unused bytes neither written nor read back
                reg_req   <= 1'b1;
                reg_we    <= wr_q;
                reg_addr  <= {addr_q[15:2], half_q, 1'b0};
                reg_be    <= ~lane_be_n & reg_used;  // R22
                reg_wdata <= din_s;  // R20
                reg_pal   <= pal_hit;
                st_q      <= ST_REGW;
              end
            end
          end
        end
        ST_MEMWR:
        begin
          if (!wq_full)
            st_q <= ST_RDY;  // R17
        end
        ST_MEMRD:
        begin
          // Reads wait for queued writes so data is never stale
          if (!rd_pend_q && wq_empty)
          begin
            mem_rd_req  <= 1'b1;
            mem_rd_addr <= {addr_q[16:2], half_q};
            rd_pend_q   <= 1'b1;
          end
          if (rd_pend_q && mem_rd_valid)
          begin
            rd_pend_q <= 1'b0;
            data_out  <= mem_rd_data;
            st_q      <= ST_RDY;  // R16
          end
        end
        ST_REGW:
        begin
          if (tmr_done)
          begin
            // Even byte on low lane, odd byte on high lane
            data_out <= {reg_used[1] ? reg_rdata[15:8] : 8'h00,
                         reg_used[0] ? reg_rdata[7:0] : 8'h00};  // R20 R22
            st_q     <= ST_RDY;  // R21
          end
        end
        ST_RDY:
        begin
          if (bus_tick)
          begin
            // Burst last still high means another transfer follows
            if (more_half || blast_s)
            begin
              // Next transfer proceeds without a fresh strobe
              if (half_q)
              begin
                addr_q <= addr_q + 24'h000001;
                half_q <= 1'b0;
              end
              else
                half_q <= 1'b1;
              if (!more_half)
                be_q <= 4'h0;
              st_q <= ST_DEC;  // R1
            end
            else
            begin
              hi_cnt_q <= RDY_HI_W[2:0];
              st_q     <= ST_RDYHI;
            end
          end
        end
        ST_RDYHI:
        begin
          hi_cnt_q <= hi_cnt_q - 3'h1;
          if (hi_cnt_q <= 3'h1)
          begin
            claim_q <= 1'b0;
            if (pipe_ok && take_ads)
            begin
              // Pipelined address caught without a next-address pin
              addr_q <= addr_s;  // R11 R8
              be_q   <= be_s;
              mio_q  <= mio_s;
              wr_q   <= wr_s;
              uas_q  <= 1'b0;
              half_q <= (be_s[1:0] == 2'h3);
              st_q   <= ST_DEC;
            end
            else
              st_q <= ST_IDLE;  // R12
          end
        end
        default:
        begin
          st_q    <= ST_IDLE;
          claim_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      ldev_n  <= 1'b1;
      lbs16_n <= 1'b1;
      rdy_out <= 1'b1;
      rdy_oe  <= 1'b0;
      data_oe <= 1'b0;
    end
    else
    begin
      ldev_n  <= ~(claim_q | ((st_q == ST_DEC) & hit));  // R3 R24
      // Wide hosts are told each claimed cycle is 16-bit
      lbs16_n <= ~(((st_q == ST_DEC) & hit | claim_q) & (mode_q != `LBT_HM_N16));  // R13
      // Ready floats except its low clock and brief high drive
      rdy_oe  <= (st_q == ST_RDY) | (st_q == ST_RDYHI) | (rdy_oe & ~rdy_out);  // R15 R24
      rdy_out <= (st_q != ST_RDY);  // R15
      data_oe <= claim_q & ~wr_q & ((st_q == ST_RDY) | (st_q == ST_REGW) | (st_q == ST_MEMRD));
    end
  end

endmodule // lbt_local_bus_target

// [inc/lbt_map.vh]
// Constants for the local bus target interface
`ifndef LBT_MAP_VH
`define LBT_MAP_VH

// Core clock rate
`define LBT_CLK_MHZ        100
// Ready driven high before release, least time
`define LBT_RDY_HIGH_NS    5
`define LBT_RDY_HIGH_CYC   (((`LBT_RDY_HIGH_NS * `LBT_CLK_MHZ) + 999) / 1000)
// Ready delays in periods of the ticking clock
`define LBT_IO_DELAY       3'h4
`define LBT_DAC_DELAY      3'h4

// Memory window, address bits 25..17
`define LBT_MEM_BASE       9'h005
// I/O window as dword index, address bits 15..2
`define LBT_IO_LO          14'h00EC
`define LBT_IO_HI          14'h00F7
// Special cycle dword indices never claimed
`define LBT_SPC_LO         14'h0000
`define LBT_SPC_HI         14'h0001
// Palette converter dwords and halves
`define LBT_PAL_W0         14'h00F1
`define LBT_PAL_W1         14'h00F2

// Host mode strap codes
`define LBT_HM_W32         2'h0
`define LBT_HM_N16         2'h1
`define LBT_HM_D32         2'h2

// Write queue geometry
`define LBT_WQ_AW          2
`define LBT_WQ_DEPTH       4

`endif

// [rtl/lbt_ready_timer.v]
// Ready delay counter for register and palette accesses
`timescale 1ns/10ps
module lbt_ready_timer (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       start,
  input  wire [2:0] load,
  input  wire       tick,
  output reg        done
);

  reg [2:0] cnt_q;
  reg       busy_q;

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_q  <= 3'h0;
      busy_q <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_q  <= load;
        busy_q <= 1'b1;
      end
      else if (busy_q && tick)
      begin
        if (cnt_q == 3'h1)
        begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end

endmodule // lbt_ready_timer

// [verification/lbt_local_bus_target_monitor.sv]
// Assertion checker for the local bus target
`timescale 1ns/10ps
`include "lbt_map.vh"
module lbt_local_bus_target_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [1:0]  host_mode,
  input wire logic        ads_n,
  input wire logic        mio,
  input wire logic [25:2] addr,
  input wire logic [15:0] data_out,
  input wire logic        ldev_n,
  input wire logic        lbs16_n,
  input wire logic        rdy_out,
  input wire logic        rdy_oe,
  input wire logic        reg_req,
  input wire logic        reg_we,
  input wire logic [1:0]  reg_be,
  input wire logic        reg_pal,
  input wire logic        mem_rd_req,
  input wire logic        mem_rd_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Pending display read; ready must wait for the data
  logic rd_wait_q;
  logic rd_wait_d;
  always_comb rd_wait_d = mem_rd_req ? 1'b1 : (mem_rd_valid ? 1'b0 : rd_wait_q);
  always_ff @(posedge core_clk) rd_wait_q <= rst ? 1'b0 : rd_wait_d;
  ////////////////////////////////////////////////////////////////
  sequence s_rdy_low;
    rdy_oe && !rdy_out;
  endsequence
  sequence s_rdy_high;
    rdy_oe && rdy_out;
  endsequence
  property p_rdy_pulse;
    $rose(rdy_oe) |-> s_rdy_low ##1 s_rdy_high ##1 !rdy_oe;
  endproperty
  property p_claim;
    rdy_oe |-> !ldev_n;
  endproperty
  property p_size;
    (!ldev_n && host_mode != `LBT_HM_N16) |-> !lbs16_n;
  endproperty
  property p_reg_dly;
    (reg_req && !reg_pal) |=> !rdy_oe [*4];
  endproperty
  // Four slow edges through two flops need eight core cycles at least
  property p_pal_dly;
    (reg_req && reg_pal) |=> !rdy_oe [*8];
  endproperty
  property p_reg_ans;
    reg_req |-> ##[1:60] $rose(rdy_oe);
  endproperty
  property p_zero;
    (reg_req && !reg_we && reg_be == 2'b00) |-> ##[1:60] ($rose(rdy_oe) && data_out == 16'h0000);
  endproperty
  property p_rd_hold;
    rd_wait_q |-> !rdy_oe;
  endproperty
  property p_special;
    (!ads_n && !mio && addr < 24'h000002 && ldev_n && !rdy_oe) |=> ldev_n [*6];
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready pulse shape wrong");
  a_claim:     assert property (p_claim) else $error("ready without claim");
  a_size:      assert property (p_size) else $error("size line high while claimed");
  a_reg_dly:   assert property (p_reg_dly) else $error("register ready too early");
  a_pal_dly:   assert property (p_pal_dly) else $error("palette ready too early");
  a_reg_ans:   assert property (p_reg_ans) else $error("register access unanswered");
  a_zero:      assert property (p_zero) else $error("unused read not zero");
  a_rd_hold:   assert property (p_rd_hold) else $error("read ready before data");
  a_special:   assert property (p_special) else $error("special cycle claimed");
endmodule // lbt_local_bus_target_monitor

bind lbt_local_bus_target lbt_local_bus_target_monitor mon_i (
  .core_clk(core_clk), .rst(rst), .host_mode(host_mode), .ads_n(ads_n), .mio(mio),
  .addr(addr), .data_out(data_out), .ldev_n(ldev_n), .lbs16_n(lbs16_n), .rdy_out(rdy_out),
  .rdy_oe(rdy_oe), .reg_req(reg_req), .reg_we(reg_we), .reg_be(reg_be), .reg_pal(reg_pal),
  .mem_rd_req(mem_rd_req), .mem_rd_valid(mem_rd_valid));

// [verification/lbt_host_model.sv]
// Host bus master model for the local bus target
`timescale 1ns/10ps
module lbt_host_model (
  input  wire logic        core_clk,
  input  wire logic        rdy_n,
  input  wire logic [15:0] data_out,
  output logic             ads_n,
  output logic             blast_n,
  output logic             mio,
  output logic             wr,
  output logic [3:0]       be_n,
  output logic [25:2]      addr,
  output logic [15:0]      data_in
);
  initial
  begin
    ads_n = 1'b1;
    blast_n = 1'b1;
    mio = 1'b0;
    wr = 1'b0;
    be_n = 4'hF;
    addr = 24'h000000;
    data_in = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////
  // One strobe clock; the rest held until ready or the limit
  task automatic run(input logic m, input logic w, input logic [25:2] a, input logic [3:0] b,
                     input logic [15:0] d, output logic [15:0] q, output int n);
    @(posedge core_clk);
    ads_n <= 1'b0;
    blast_n <= 1'b0;
    mio <= m;
    wr <= w;
    addr <= a;
    be_n <= b;
    data_in <= d;
    @(posedge core_clk);
    ads_n <= 1'b1;
    n = 1;
    // Only this target answers here; no other device joins in
    while (rdy_n !== 1'b0 && n < 60)
    begin
      @(posedge core_clk);
      n++;
    end
    q = data_out;
    // Released lines show no stale value
    addr <= ~a;
    data_in <= ~d;
    be_n <= 4'hF;
  endtask
endmodule // lbt_host_model

// [verification/lbt_local_bus_target_bench.sv]
// Self-checking bench for the local bus target
`timescale 1ns/10ps
`include "lbt_map.vh"
module lbt_local_bus_target_bench;
  localparam int          RDLAT = 10;
  localparam logic [15:0] MEMW  = 16'hBEEF;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        video_clock = 1'b0;
  logic [1:0]  host_mode = `LBT_HM_W32;
  logic        upper_address_select_n = 1'b0;
  logic [1:0]  reg_used = 2'b11;
  logic [15:0] reg_rdata = 16'h0000;
  logic        mem_wr_ready = 1'b0;
  logic        mem_rd_valid = 1'b0;
  logic [15:0] mem_rd_data = 16'h0000;
  logic        ads_n, blast_n, mio, wr, ldev_n, lbs16_n, rdy_out, rdy_oe;
  logic        reg_req, reg_we, reg_pal, mem_wr_valid, mem_rd_req;
  logic [3:0]  be_n;
  logic [25:2] addr;
  logic [15:0] data_in, data_out, reg_addr, reg_wdata, mem_wr_data, mem_wr_addr, mem_rd_addr;
  logic [1:0]  reg_be, mem_wr_be;
  wire         rdy_n = rdy_oe ? rdy_out : 1'b1;
  int          errors = 0;
  int          compares = 0;
  ////////////////////////////////////////////////////////////////
  lbt_local_bus_target lbt_local_bus_target_i (
    .core_clk(core_clk), .rst(rst), .host_mode(host_mode), .ads_n(ads_n), .blast_n(blast_n),
    .mio(mio), .wr(wr), .be_n(be_n), .addr(addr), .upper_address_select_n(upper_address_select_n),
    .data_in(data_in), .data_out(data_out), .data_oe(), .ldev_n(ldev_n), .lbs16_n(lbs16_n),
    .rdy_out(rdy_out), .rdy_oe(rdy_oe), .video_clock(video_clock), .reg_req(reg_req),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_pal(reg_pal),
    .reg_used(reg_used), .reg_rdata(reg_rdata), .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_wr_be(mem_wr_be), .mem_wr_ready(mem_wr_ready),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
  lbt_host_model host_i (
    .core_clk(core_clk), .rdy_n(rdy_n), .data_out(data_out), .ads_n(ads_n), .blast_n(blast_n),
    .mio(mio), .wr(wr), .be_n(be_n), .addr(addr), .data_in(data_in));
  ////////////////////////////////////////////////////////////////
  initial forever #5 core_clk = ~core_clk;
  // Palette clock runs slower and out of phase with the core
  initial #7 forever #15 video_clock = ~video_clock;
  always @(posedge core_clk)
    if (mem_rd_req)
    begin
      repeat (RDLAT) @(posedge core_clk);
      mem_rd_valid <= 1'b1;
      mem_rd_data <= MEMW;
      @(posedge core_clk);
      mem_rd_valid <= 1'b0;
      mem_rd_data <= ~MEMW;
    end
  ////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input string what);
    compares++;
    if (got !== 1'b1)
    begin
      errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reg_rw;
    logic [15:0] q;
    int          n;
    reg_rdata <= 16'h5AA5;
    host_i.run(1'b0, 1'b0, 24'h0000F0, 4'hE, 16'h0000, q, n);
    chk_val({8'h00, q[7:0]}, 16'h00A5, "even lane");
    chk_flag(n >= 6 && n < 60, "register delay");
    chk_val(reg_addr, 16'h03C0, "register address");
    chk_flag(reg_pal === 1'b0, "palette flag");
    host_i.run(1'b0, 1'b0, 24'h0000F0, 4'hD, 16'h0000, q, n);
    chk_val({q[15:8], 8'h00}, 16'h5A00, "odd lane");
    host_i.run(1'b0, 1'b1, 24'h0000F0, 4'hD, 16'hC3C3, q, n);
    chk_val(reg_wdata & 16'hFF00, 16'hC300, "write lane");
    chk_flag(reg_we === 1'b1 && reg_be === 2'b10, "write enables");
    $display("test reg_rw done");
  endtask
  task automatic t_unused;
    logic [15:0] q;
    int          n;
    reg_used <= 2'b00;
    host_i.run(1'b0, 1'b0, 24'h0000F0, 4'hE, 16'h0000, q, n);
    chk_flag(n < 60, "unused answered");
    chk_val({8'h00, q[7:0]}, 16'h0000, "unused read");
    host_i.run(1'b0, 1'b1, 24'h0000F0, 4'hE, 16'h00FF, q, n);
    chk_flag(reg_be === 2'b00 && n < 60, "unused write");
    reg_used <= 2'b11;
    $display("test unused done");
  endtask
  task automatic t_palette;
    logic [15:0] q;
    int          n;
    host_i.run(1'b0, 1'b0, 24'h0000F2, 4'hE, 16'h0000, q, n);
    chk_flag(n >= 12 && n < 60, "palette delay");
    chk_flag(reg_pal === 1'b1, "palette flag");
    $display("test palette done");
  endtask
  task automatic t_refuse;
    logic [15:0] q;
    int          n;
    logic [25:2] tab [4];
    tab = '{24'h000000, 24'h000001, 24'h0000E8, 24'h028000};
    for (int i = 0; i < 4; i++)
    begin
      upper_address_select_n <= (i == 3);
      host_i.run(i == 3, 1'b0, tab[i], 4'hE, 16'h0000, q, n);
      chk_flag(n == 60, "refused cycle");
    end
    upper_address_select_n <= 1'b0;
    $display("test refuse done");
  endtask
  task automatic t_mem;
    logic [15:0] q;
    int          n;
    host_i.run(1'b1, 1'b1, 24'h028000, 4'hC, 16'h1234, q, n);
    chk_flag(n < 12, "write released");
    chk_flag(mem_wr_valid === 1'b1, "write queued");
    chk_val(mem_wr_data, 16'h1234, "queued data");
    chk_val(mem_wr_addr, 16'h0000, "queued address");
    chk_val({14'h0000, mem_wr_be}, 16'h0003, "queued enables");
    mem_wr_ready <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk_flag(mem_wr_valid === 1'b0, "queue drained");
    host_i.run(1'b1, 1'b0, 24'h028000, 4'hC, 16'h0000, q, n);
    chk_val(q, MEMW, "read data");
    chk_val(mem_rd_addr, 16'h0000, "read address");
    chk_flag(n >= RDLAT + 3 && n < 60, "read waits");
    $display("test mem done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reg_rw;
    t_unused;
    t_palette;
    t_refuse;
    t_mem;
    end_sim;
  end
  // Tests need under a thousand cycles; ten times that means a hang
  initial
  begin
    repeat (10000) @(posedge core_clk);
    errors++;
    end_sim;
  end
endmodule // lbt_local_bus_target_bench
